// file: bench/sazd_master_model.sv
// Core bus master model that issues one access per cycle
`timescale 1ns/100ps
module sazd_master_model (
   input wire logic clk, // Core clock
   output logic req_valid, // Access strobe
   output logic req_write, // 1 write, 0 read
   output logic [23:0] req_addr // Byte address
);
   // Bus quiet at time zero
   initial begin
      req_valid = 1'b0;
      req_write = 1'b0;
      req_addr = 24'h000000;
   end

   // Drive one access after a falling edge; held through the sampling edge
   // Callers walk every region edge, reserved-gap addresses included
   task automatic issue(input logic [23:0] a, input logic w);
      @(negedge clk);
      req_valid <= 1'b1;
      req_write <= w;
      req_addr <= a;
   endtask

   // Release the bus; lines show the inverse of the last value, not a stale copy
   task automatic idle();
      @(negedge clk);
      req_valid <= 1'b0;
      req_write <= ~req_write;
      req_addr <= ~req_addr;
   endtask
endmodule

// file: bench/system_address_zone_decoder_tb.sv
// Self-checking testbench for the system address zone decoder
`timescale 1ns/100ps
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin errors++; \
   $display("CHECK FAILED %s expected %h seen %h", n, e, g); end end
module system_address_zone_decoder_tb;
   import sazd_pkg::*;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [1:0] env_mode = 2'h0;
   logic req_valid;
   logic req_write;
   logic [23:0] req_addr;
   sazd_route_type route;
   logic flash_enable;
   int errors = 0;
   int comparisons = 0;
   // Region edges, reserved gaps among them
   logic [23:0] pts [22] = '{24'h000000, 24'h03ffff, 24'h040000, 24'h0e0000, 24'h0e1fff,
      24'h0e2000, 24'h0ec000, 24'h0ee7ff, 24'h0ef000, 24'h0ef13f, 24'h0ef140, 24'h3fffff,
      24'h400000, 24'h7fffff, 24'h800000, 24'hfeffff, 24'hff0000, 24'hfffaff, 24'hfffb00,
      24'hfffbff, 24'hfffc00, 24'hffffff};

   always #12.5 clk = ~clk;

   sazd_master_model master (.clk(clk), .req_valid(req_valid), .req_write(req_write),
      .req_addr(req_addr));
   sazd_decoder uut (.clk(clk), .rst_n(rst_n), .env_mode(env_mode), .req_valid(req_valid),
      .req_write(req_write), .req_addr(req_addr), .route(route), .flash_enable(flash_enable));

   // Expected {reserved, target, zone} for an address
   function automatic logic [13:0] exp_of(input logic [23:0] a, input logic develop);
      if (a <= 24'h03ffff) return {1'b0, develop ? 10'h010 : 10'h001, 3'h1};
      if (a >= 24'h0e0000 && a <= 24'h0e1fff) return {1'b0, develop ? 10'h010 : 10'h002, 3'h1};
      if (a >= 24'h0ec000 && a <= 24'h0ee7ff) return {1'b0, 10'h004, 3'h0};
      if (a >= 24'h0ef000 && a <= 24'h0ef13f) return {1'b0, 10'h008, 3'h0};
      if (a >= 24'h400000 && a <= 24'h7fffff) return {1'b0, 10'h010, 3'h2};
      if (a >= 24'h800000 && a <= 24'hfeffff) return {1'b0, 10'h010, 3'h3};
      if (a >= 24'hff0000 && a <= 24'hfffaff) return {1'b0, 10'h020, 3'h0};
      if (a >= 24'hfffb00 && a <= 24'hfffbff) return {1'b0, 10'h040, 3'h4};
      if (a >= 24'hfffc00) return {1'b0, 10'h080, 3'h0};
      return {1'b1, 10'h000, 3'h0};
   endfunction

   // Reset in a given environment, then check the quiet result
   task automatic do_reset(input logic [1:0] env);
      @(negedge clk);
      rst_n <= 1'b0;
      env_mode <= env;
      repeat (4) @(negedge clk);
      rst_n <= 1'b1;
      `CHK("route_in_reset", 40'h0, route)
      `CHK("flash_enable", env != 2'h2, flash_enable)
   endtask

   // Back-to-back accesses over every region edge, then an idle cycle
   task automatic t_map(input logic develop);
      logic [13:0] e;
      foreach (pts[i]) begin
         master.issue(pts[i], i[0]);
         @(posedge clk);
         #2;
         e = exp_of(pts[i], develop);
         `CHK("target", e[12:3], route.target)
         `CHK("one_target", 1'b1, $onehot0(route.target))
         `CHK("zone", e[2:0], route.zone)
         `CHK("reserved_hit", e[13], route.reserved_hit)
         `CHK("addr", pts[i], route.addr)
         `CHK("valid_write", {1'b1, i[0]}, {route.valid, route.write})
      end
      master.idle();
      @(posedge clk);
      #2;
      `CHK("idle", 14'h0, {route.valid, route.target, route.zone})
   endtask

   // Print counts and verdict, then stop
   task automatic wrap_up();
      $display("Comparisons %0d, errors %0d", comparisons, errors);
      if (errors == 0 && comparisons > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   // Main sequence: every environment code, reset before each
   initial begin
      for (int e = 0; e < 4; e++) begin
         do_reset(e[1:0]);
         t_map(e == 2);
      end
      wrap_up();
   end

   // Watchdog well beyond the expected run length
   initial begin
      #(2000 * 25);
      errors++;
      wrap_up();
   end
endmodule

// file: hw/sazd_decoder.sv
// System address zone decoder: steers each core access to at most one target
//
// Notes on behaviour
// R1 - The core sees one flat 16 Mbyte byte space and every address hits at most one target.
// R2 - 00_0000h to 03_FFFFh selects program flash with its boot area, in static zone 0.
// R3 - 0E_0000h to 0E_1FFFh selects data flash, also in static zone 0.
// R4 - Zone 0 goes to flash in internal and external code modes, to the external bus in development.
// R5 - 0E_F000h to 0E_F13Fh selects the network-controller buffers and registers.
// R6 - 40_0000h to 7F_FFFFh goes to external memory under static zone 1 timing.
// R7 - 80_0000h to FE_FFFFh goes to external memory under static zone 2 timing.
// R8 - FF_FC00h to FF_FFFFh selects the general peripheral block, in no bus zone.
// R9 - The master must never access a reserved address range; the decoder flags such an access with reserved_hit and routes it nowhere.
// R10 - Every access inside one bus zone carries that zone's single tag.
// R11 - In development mode the flash is disabled and its space is served externally.
// R12 - System RAM, bus-unit peripherals and the I/O expansion zone sit at their fixed ranges.
`timescale 1ns/100ps
module sazd_decoder
   import sazd_pkg::*;
(
   input wire logic clk, // 40 MHz core clock
   input wire logic rst_n, // Synchronous reset, active low
   input wire logic [1:0] env_mode, // Operating environment, held static
   input wire logic req_valid, // Access request strobe
   input wire logic req_write, // 1 write, 0 read
   input wire logic [23:0] req_addr, // Byte address
   output sazd_route_type route, // Registered decode result
   output logic flash_enable // Flash usable in this mode
);

   //----------------------------------------
   // Combinational decode
   //----------------------------------------
   logic [1:0] env_meta_ff;
   logic [1:0] env_sync_ff;
   logic develop_mode;
   sazd_target_type nxt_target;
   sazd_zone_type nxt_zone;
   sazd_route_type route_ff;

   //----------------------------------------
   // Environment synchroniser
   //----------------------------------------
   // Straps come from pins: two flops before any decode reads them
   // No reset, so the mode has settled by the time reset lifts
   // A strap change shows in the decode two cycles later
   always_ff @(posedge clk) begin
      env_meta_ff <= env_mode;
      env_sync_ff <= env_meta_ff;
   end

   // Development mode disables flash
   assign develop_mode = (env_sync_ff == SAZD_ENV_DEVELOPMENT);
   assign flash_enable = ~develop_mode; // R11

   // Address to target and zone; ranges are disjoint
   always_comb begin
      nxt_target = SAZD_T_NONE;
      nxt_zone = SAZD_Z_NONE;
      if (req_addr <= PFLASH_HI) begin // R2
         nxt_target = develop_mode ? SAZD_T_EXTBUS : SAZD_T_PFLASH; // R4 R11
         nxt_zone = SAZD_Z_STATIC0; // R10
      end else if (req_addr >= DFLASH_LO && req_addr <= DFLASH_HI) begin // R3
         nxt_target = develop_mode ? SAZD_T_EXTBUS : SAZD_T_DFLASH; // R4 R11
         nxt_zone = SAZD_Z_STATIC0;
      end else if (req_addr >= SRAM_LO && req_addr <= SRAM_HI) begin // R12
         nxt_target = SAZD_T_SRAM;
      end else if (req_addr >= NET_LO && req_addr <= NET_HI) begin // R5
         nxt_target = SAZD_T_NET;
      end else if (req_addr >= EXT1_LO && req_addr <= EXT1_HI) begin // R6
         nxt_target = SAZD_T_EXTBUS;
         nxt_zone = SAZD_Z_STATIC1;
      end else if (req_addr >= EXT2_LO && req_addr <= EXT2_HI) begin // R7
         nxt_target = SAZD_T_EXTBUS;
         nxt_zone = SAZD_Z_STATIC2;
      end else if (req_addr >= BUP_LO && req_addr <= BUP_HI) begin // R12
         nxt_target = SAZD_T_BUSPERI;
      end else if (req_addr >= IOX_LO && req_addr <= IOX_HI) begin // R12
         nxt_target = SAZD_T_IOEXP;
         nxt_zone = SAZD_Z_IO; // R10
      end else if (req_addr >= PERI_LO) begin // R8
         nxt_target = SAZD_T_PERI;
      end
   end

   //----------------------------------------
   // Registered route
   //----------------------------------------
   // One-cycle decode latency; reserved hits flagged, not routed
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         route_ff <= '0;
      end else begin
         route_ff.valid <= req_valid;
         route_ff.write <= req_write;
         route_ff.addr <= req_addr;
         route_ff.target <= req_valid ? nxt_target : SAZD_T_NONE; // R1
         route_ff.zone <= req_valid ? nxt_zone : SAZD_Z_NONE;
         route_ff.reserved_hit <= req_valid && (nxt_target == SAZD_T_NONE); // R9
      end
   end

   assign route = route_ff;

   //----------------------------------------
   // Assertions
   //----------------------------------------
   property p_onehot;
      @(posedge clk) disable iff (!rst_n) $onehot0(route.target);
   endproperty
   a_onehot: assert property (p_onehot) else $error("target not one-hot"); // R1

   property p_pflash;
      @(posedge clk) disable iff (!rst_n)
         (req_valid && req_addr <= PFLASH_HI && !develop_mode) |=>
         (route.target == SAZD_T_PFLASH && route.zone == SAZD_Z_STATIC0);
   endproperty
   a_pflash: assert property (p_pflash) else $error("program flash misrouted"); // R2

   property p_dflash;
      @(posedge clk) disable iff (!rst_n)
         (req_valid && req_addr >= DFLASH_LO && req_addr <= DFLASH_HI && !develop_mode) |=>
         (route.target == SAZD_T_DFLASH && route.zone == SAZD_Z_STATIC0);
   endproperty
   a_dflash: assert property (p_dflash) else $error("data flash misrouted"); // R3

   property p_develop;
      @(posedge clk) disable iff (!rst_n)
         (req_valid && develop_mode && req_addr <= PFLASH_HI) |=>
         (route.target == SAZD_T_EXTBUS && route.zone == SAZD_Z_STATIC0 &&
            !flash_enable);
   endproperty
   a_develop: assert property (p_develop) else $error("zone 0 not external in development"); // R4

   property p_net;
      @(posedge clk) disable iff (!rst_n)
         (req_valid && req_addr >= 24'h0ef000 && req_addr <= 24'h0ef13f) |=>
         (route.target == SAZD_T_NET);
   endproperty
   a_net: assert property (p_net) else $error("network buffers misrouted"); // R5

   property p_ext1;
      @(posedge clk) disable iff (!rst_n)
         (req_valid && req_addr[23:22] == 2'h1) |=>
         (route.target == SAZD_T_EXTBUS && route.zone == SAZD_Z_STATIC1);
   endproperty
   a_ext1: assert property (p_ext1) else $error("zone 1 misrouted"); // R6

   property p_ext2;
      @(posedge clk) disable iff (!rst_n)
         (req_valid && req_addr[23] && req_addr[23:16] != 8'hff) |=>
         (route.target == SAZD_T_EXTBUS && route.zone == SAZD_Z_STATIC2);
   endproperty
   a_ext2: assert property (p_ext2) else $error("zone 2 misrouted"); // R7

   property p_peri;
      @(posedge clk) disable iff (!rst_n)
         (req_valid && req_addr[23:10] == 14'h3fff) |=>
         (route.target == SAZD_T_PERI && route.zone == SAZD_Z_NONE);
   endproperty
   a_peri: assert property (p_peri) else $error("peripheral block misrouted"); // R8

   property p_zone_ext;
      @(posedge clk) disable iff (!rst_n)
         (route.zone == SAZD_Z_STATIC1 || route.zone == SAZD_Z_STATIC2) |->
         (route.target == SAZD_T_EXTBUS && route.valid);
   endproperty
   a_zone_ext: assert property (p_zone_ext) else $error("zone tag on wrong target"); // R10

   property p_misc;
      @(posedge clk) disable iff (!rst_n)
         (req_valid && req_addr[23:8] == 16'hfffb) |=>
         (route.target == SAZD_T_IOEXP && route.zone == SAZD_Z_IO);
   endproperty
   a_misc: assert property (p_misc) else $error("I/O expansion misrouted"); // R12

   //----------------------------------------
   // Refusal, idle, pass-through, region and zone-tag checks
   //----------------------------------------
   // Request in the hole between program flash and data flash
   sequence s_gap_low;
      req_valid && req_addr > PFLASH_HI && req_addr < DFLASH_LO;
   endsequence

   // Request in the wide hole just below external zone 1
   sequence s_gap_high;
      req_valid && req_addr[23:22] == 2'h0 && req_addr[21:20] != 2'h0;
   endsequence

   // Refused access: flagged and valid, but routed nowhere
   sequence s_refused;
      route.valid && route.reserved_hit && route.target == SAZD_T_NONE &&
         route.zone == SAZD_Z_NONE;
   endsequence

   property p_gap_low;
      @(posedge clk) disable iff (!rst_n) s_gap_low |=> s_refused;
   endproperty
   a_gap_low: assert property (p_gap_low) else $error("low reserved gap routed"); // R1

   property p_gap_high;
      @(posedge clk) disable iff (!rst_n) s_gap_high |=> s_refused;
   endproperty
   a_gap_high: assert property (p_gap_high) else $error("high reserved gap routed"); // R1

   // Quiet bus gives a quiet route one cycle later
   property p_idle;
      @(posedge clk) disable iff (!rst_n)
         !req_valid |=>
         (!route.valid && !route.reserved_hit && route.target == SAZD_T_NONE &&
            route.zone == SAZD_Z_NONE);
   endproperty
   a_idle: assert property (p_idle) else $error("route not quiet after idle"); // R1

   // Request fields carried through with exactly one cycle of latency
   property p_carry;
      @(posedge clk) disable iff (!rst_n)
         req_valid |=>
         (route.valid && route.addr == $past(req_addr) && route.write == $past(req_write));
   endproperty
   a_carry: assert property (p_carry) else $error("request fields not carried"); // R1

   property p_sram;
      @(posedge clk) disable iff (!rst_n)
         (req_valid && req_addr >= SRAM_LO && req_addr <= SRAM_HI) |=>
         (route.target == SAZD_T_SRAM && route.zone == SAZD_Z_NONE &&
            !route.reserved_hit);
   endproperty
   a_sram: assert property (p_sram) else $error("system RAM misrouted"); // R12

   property p_busperi;
      @(posedge clk) disable iff (!rst_n)
         (req_valid && req_addr >= BUP_LO && req_addr <= BUP_HI) |=>
         (route.target == SAZD_T_BUSPERI && route.zone == SAZD_Z_NONE &&
            !route.reserved_hit);
   endproperty
   a_busperi: assert property (p_busperi) else $error("bus-unit peripherals misrouted"); // R12

   // Data flash space also moves to the external bus in development mode
   property p_develop_data;
      @(posedge clk) disable iff (!rst_n)
         (req_valid && develop_mode && req_addr >= DFLASH_LO && req_addr <= DFLASH_HI) |=>
         (route.target == SAZD_T_EXTBUS && route.zone == SAZD_Z_STATIC0);
   endproperty
   a_develop_data: assert property (p_develop_data) else $error("data flash not external"); // R11

   // Zone 0 tag only ever rides on flash or its external stand-in
   property p_zone0;
      @(posedge clk) disable iff (!rst_n)
         (route.zone == SAZD_Z_STATIC0) |->
         (route.valid && (route.target == SAZD_T_PFLASH || route.target == SAZD_T_DFLASH ||
            route.target == SAZD_T_EXTBUS));
   endproperty
   a_zone0: assert property (p_zone0) else $error("zone 0 tag on wrong target"); // R10

   // I/O zone tag only ever rides on the expansion target
   property p_zone_io;
      @(posedge clk) disable iff (!rst_n)
         (route.zone == SAZD_Z_IO) |-> (route.valid && route.target == SAZD_T_IOEXP);
   endproperty
   a_zone_io: assert property (p_zone_io) else $error("I/O zone tag on wrong target"); // R10

endmodule

// file: shared/sazd_pkg.sv
// Package for the system address zone decoder: ranges, targets, zones
package sazd_pkg;

   //----------------------------------------
   // Address space
   //----------------------------------------
   localparam int ADDR_W = 24;

   //----------------------------------------
   // Region bounds (inclusive)
   //----------------------------------------
   localparam logic [23:0] PFLASH_LO = 24'h000000;
   localparam logic [23:0] PFLASH_HI = 24'h03ffff;
   localparam logic [23:0] DFLASH_LO = 24'h0e0000;
   localparam logic [23:0] DFLASH_HI = 24'h0e1fff;
   localparam logic [23:0] SRAM_LO = 24'h0ec000;
   localparam logic [23:0] SRAM_HI = 24'h0ee7ff;
   localparam logic [23:0] NET_LO = 24'h0ef000;
   localparam logic [23:0] NET_HI = 24'h0ef13f;
   localparam logic [23:0] EXT1_LO = 24'h400000;
   localparam logic [23:0] EXT1_HI = 24'h7fffff;
   localparam logic [23:0] EXT2_LO = 24'h800000;
   localparam logic [23:0] EXT2_HI = 24'hfeffff;
   localparam logic [23:0] BUP_LO = 24'hff0000;
   localparam logic [23:0] BUP_HI = 24'hfffaff;
   localparam logic [23:0] IOX_LO = 24'hfffb00;
   localparam logic [23:0] IOX_HI = 24'hfffbff;
   localparam logic [23:0] PERI_LO = 24'hfffc00;
   localparam logic [23:0] PERI_HI = 24'hffffff;

   //----------------------------------------
   // Environment strap codes
   //----------------------------------------
   typedef enum logic [1:0] {
      SAZD_ENV_INTERNAL_CODE = 2'h0,
      SAZD_ENV_EXTERNAL_CODE = 2'h1,
      SAZD_ENV_DEVELOPMENT = 2'h2
   } sazd_env_type;

   //----------------------------------------
   // Targets, one-hot; zero means reserved
   //----------------------------------------
   typedef enum logic [9:0] {
      SAZD_T_NONE = 10'h000,
      SAZD_T_PFLASH = 10'h001,
      SAZD_T_DFLASH = 10'h002,
      SAZD_T_SRAM = 10'h004,
      SAZD_T_NET = 10'h008,
      SAZD_T_EXTBUS = 10'h010,
      SAZD_T_BUSPERI = 10'h020,
      SAZD_T_IOEXP = 10'h040,
      SAZD_T_PERI = 10'h080
   } sazd_target_type;

   //----------------------------------------
   // Bus-interface zones
   //----------------------------------------
   typedef enum logic [2:0] {
      SAZD_Z_NONE = 3'h0,
      SAZD_Z_STATIC0 = 3'h1,
      SAZD_Z_STATIC1 = 3'h2,
      SAZD_Z_STATIC2 = 3'h3,
      SAZD_Z_IO = 3'h4
   } sazd_zone_type;

   //----------------------------------------
   // Decoded access carrier
   //----------------------------------------
   typedef struct packed {
      logic valid;
      logic write;
      logic [23:0] addr;
      sazd_target_type target;
      sazd_zone_type zone;
      logic reserved_hit;
   } sazd_route_type;

endpackage
